// ---- common/fcv_pkg.sv ----
// Shared constants and types of the flash command sequencer
package fcv_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [4:0] OFF_STATUS = 5'h00;
  localparam logic [4:0] OFF_INDEX = 5'h04;
  localparam logic [4:0] OFF_BUFWORD = 5'h08;
  localparam logic [4:0] OFF_PERMIT = 5'h0c;
  localparam logic [4:0] OFF_PROT = 5'h10;

  // ---------------------------------------------------------------
  // Status and control field positions
  // ---------------------------------------------------------------
  localparam int ST_CMPL = 7;
  localparam int ST_ACC_ERR = 5;
  localparam int ST_PROT_VIOL = 4;
  localparam int ST_MGS1 = 1;
  localparam int ST_MGS0 = 0;
  localparam int PRM_EV = 0;
  localparam int PRM_RO = 1;
  localparam int PRM_PG = 2;
  localparam int PROT_EN = 31;
  localparam logic [2:0] PERMIT_RST = 3'h7;

  // ---------------------------------------------------------------
  // Commands and buffer layout
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_EV = 8'h03;
  localparam logic [7:0] CMD_RO = 8'h04;
  localparam logic [7:0] CMD_PG = 8'h06;
  localparam logic [2:0] IX_EV = 3'h2;
  localparam logic [2:0] IX_RO = 3'h1;
  localparam logic [2:0] IX_PG = 3'h5;
  localparam int BUF_WORDS = 6;
  localparam int BW_CMD = 0;
  localparam int BW_LO = 1;
  localparam int BW_CNT = 2;
  localparam int BW_DATA = 2;
  localparam logic [15:0] RO_MAX_IX = 16'h0007;

  // ---------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------
  localparam int PF_BLK_LSB = 18;
  localparam logic [4:0] PF_BLK_SEL = 5'h1f;
  localparam logic [19:0] SECT_BYTES = 20'h4_0000;
  localparam logic [22:0] PHRASE_BYTES = 23'h00_0008;
  localparam logic [63:0] ERASED = 64'hffff_ffff_ffff_ffff;
  localparam logic [15:0] FETCH_INVALID = 16'h0000;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_CHECK = 7'h02,
    ST_EVRD  = 7'h04,
    ST_RORD  = 7'h08,
    ST_PGWR  = 7'h10,
    ST_PGRD  = 7'h20,
    ST_DONE  = 7'h40
  } fcv_state_t;

  typedef struct packed {
    logic we;
    logic info;
    logic [22:0] addr;
    logic [63:0] wdata;
  } fcv_arr_req_t;

  typedef struct packed {
    logic [63:0] rdata;
    logic err;
    logic uncorr;
  } fcv_arr_rsp_t;

  function automatic logic fcv_in_pflash(input logic [22:0] addr);
    return addr[22:PF_BLK_LSB] == PF_BLK_SEL;
  endfunction

endpackage

// ---- hw/fcv_arr_port.sv ----
// Single-transfer array access port with request held until acknowledge
module fcv_arr_port (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire fcv_pkg::fcv_arr_req_t cmd_i,
  input wire logic arr_ack_i,
  input wire fcv_pkg::fcv_arr_rsp_t arr_rsp_i,
  output logic arr_valid_o,
  output fcv_pkg::fcv_arr_req_t arr_req_o,
  output logic done_o,
  output fcv_pkg::fcv_arr_rsp_t rsp_o
);

  logic valid_d;
  logic take;

  assign take = arr_valid_o && arr_ack_i;
  assign valid_d = start_i || (arr_valid_o && !arr_ack_i);

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      arr_valid_o <= 1'b0;
      arr_req_o <= '0;
      done_o <= 1'b0;
      rsp_o <= '0;
    end
    else
    begin
      arr_valid_o <= valid_d;
      done_o <= take;
      if (start_i)
        arr_req_o <= cmd_i;
      if (take)
        rsp_o <= arr_rsp_i;
    end
  end

endmodule // fcv_arr_port

// ---- hw/fcv_sequencer.sv ----
// Flash command sequencer: section erase-verify, one-time read, phrase program
// Function
// - Erase-verify: word0 command and address high, word1 address low, word2 count.
// - Erase-verify range crossing a 256 Kbyte boundary raises access error.
// - Erase-verify launched with index other than 010 raises access error.
// - Erase-verify start address with nonzero low three bits raises access error.
// - Erase-verify address outside the program array raises access error.
// - Command not permitted in current mode raises access error, not executed.
// - Array read errors set verify error; uncorrectable errors set second bit.
// - Clearing complete flag launches; flag stays clear until operation ends.
// - One-time read: word0 command, word1 phrase index 0-7, words2-5 results.
// - One-time read writes four fetched 16-bit words into buffer words.
// - One-time read launched with index other than 001 raises access error.
// - One-time read phrase index above seven raises access error.
// - Program array fetches return invalid data while one-time read runs.
// - One-time field is eight phrases in block 0 information region.
// - Program: word0 command and address high, word1 address low, words2-5 data.
// - Program writes the phrase, then reads back and compares.
// - Illegal command sequence raises access error and is not processed.
// - Program launched with index other than 101 raises access error.
// - Program into protected region raises protection violation, no write.
module fcv_sequencer (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic arr_valid_o,
  output fcv_pkg::fcv_arr_req_t arr_req_o,
  input wire logic arr_ack_i,
  input wire fcv_pkg::fcv_arr_rsp_t arr_rsp_i,
  input wire logic [22:0] fetch_addr_i,
  input wire logic [15:0] fetch_rdata_i,
  output logic [15:0] fetch_rdata_o,
  output logic fetch_invalid_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  fcv_pkg::fcv_state_t st_q, st_d;
  logic [15:0] buf_q [fcv_pkg::BUF_WORDS];
  logic [2:0] ix_q;
  logic [2:0] permit_q;
  logic prot_en_q;
  logic [22:0] prot_bound_q;
  logic cmpl_q, acc_err_q, prot_viol_q, mgs1_q, mgs0_q;
  logic [22:0] cur_addr_q;
  logic [15:0] cnt_q;
  logic [31:0] rdata_q;
  logic wait_q;
  logic [15:0] fetch_q;
  logic fetch_inv_q;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire req = (avs_read_i || avs_write_i) && wait_q;
  wire wr = avs_write_i && !wait_q && avs_byteenable_i[0];
  wire idle = st_q == fcv_pkg::ST_IDLE;
  wire wr_status = wr && avs_address_i == fcv_pkg::OFF_STATUS && idle;
  wire wr_index = wr && avs_address_i == fcv_pkg::OFF_INDEX && idle;
  wire wr_buf = wr && avs_address_i == fcv_pkg::OFF_BUFWORD && idle
                && 32'(ix_q) < fcv_pkg::BUF_WORDS;
  wire wr_permit = wr && avs_address_i == fcv_pkg::OFF_PERMIT;
  wire wr_prot = wr && avs_address_i == fcv_pkg::OFF_PROT;
  // Launch only from a clean state; stale errors must be cleared first
  wire launch = wr_status && avs_writedata_i[fcv_pkg::ST_CMPL] && cmpl_q
                && !acc_err_q && !prot_viol_q;
  wire clr_acc = wr_status && avs_writedata_i[fcv_pkg::ST_ACC_ERR];
  wire clr_fpv = wr_status && avs_writedata_i[fcv_pkg::ST_PROT_VIOL];

  wire [7:0] status_w = {cmpl_q, 1'b0, acc_err_q, prot_viol_q, 2'b00, mgs1_q, mgs0_q};
  wire [15:0] buf_rd = (32'(ix_q) < fcv_pkg::BUF_WORDS) ? buf_q[ix_q] : 16'h0000;
  logic [31:0] rd_mux;
  always_comb
  begin
    unique case (avs_address_i)
      fcv_pkg::OFF_STATUS: rd_mux = {24'h00_0000, status_w};
      fcv_pkg::OFF_INDEX: rd_mux = {29'h0000_0000, ix_q};
      fcv_pkg::OFF_BUFWORD: rd_mux = {16'h0000, buf_rd};
      fcv_pkg::OFF_PERMIT: rd_mux = {29'h0000_0000, permit_q};
      fcv_pkg::OFF_PROT: rd_mux = {prot_en_q, 8'h00, prot_bound_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // Command decode and launch checks
  // ---------------------------------------------------------------
  wire [7:0] cmd = buf_q[fcv_pkg::BW_CMD][15:8];
  wire [22:0] op_addr = {buf_q[fcv_pkg::BW_CMD][6:0], buf_q[fcv_pkg::BW_LO]};
  wire [15:0] ev_cnt = buf_q[fcv_pkg::BW_CNT];
  wire is_ev = cmd == fcv_pkg::CMD_EV;
  wire is_ro = cmd == fcv_pkg::CMD_RO;
  wire is_pg = cmd == fcv_pkg::CMD_PG;
  wire addr_bad = !fcv_pkg::fcv_in_pflash(op_addr);
  wire misalign = op_addr[2:0] != 3'h0;
  // End of range measured inside the current 256 Kbyte section
  wire [19:0] ev_end = 20'(op_addr[17:0]) + 20'({ev_cnt, 3'h0});
  wire ev_cross = ev_end > fcv_pkg::SECT_BYTES;
  wire ev_err = ix_q != fcv_pkg::IX_EV || !permit_q[fcv_pkg::PRM_EV] || addr_bad
                || misalign || ev_cross || ev_cnt == 16'h0000;
  wire ro_err = ix_q != fcv_pkg::IX_RO || !permit_q[fcv_pkg::PRM_RO]
                || buf_q[fcv_pkg::BW_LO] > fcv_pkg::RO_MAX_IX;
  wire pg_err = ix_q != fcv_pkg::IX_PG || !permit_q[fcv_pkg::PRM_PG] || addr_bad
                || misalign;
  wire pg_prot = prot_en_q && op_addr >= prot_bound_q;
  wire cmd_err = is_ev ? ev_err : is_ro ? ro_err : is_pg ? pg_err : 1'b1;
  wire chk = st_q == fcv_pkg::ST_CHECK;
  wire go = chk && !cmd_err && !(is_pg && pg_prot);

  // ---------------------------------------------------------------
  // Array access
  // ---------------------------------------------------------------
  logic arr_done;
  fcv_pkg::fcv_arr_rsp_t rsp;
  fcv_pkg::fcv_arr_req_t arr_cmd;
  wire ev_last = cnt_q == 16'h0001;
  wire ev_next = st_q == fcv_pkg::ST_EVRD && arr_done && !ev_last;
  wire pg_back = st_q == fcv_pkg::ST_PGWR && arr_done;
  wire arr_start = go || ev_next || pg_back;
  // One-time field sits in the information region, phrase index times eight
  wire [22:0] ro_addr = {17'h0_0000, buf_q[fcv_pkg::BW_LO][2:0], 3'h0};
  wire [63:0] pg_data = {buf_q[fcv_pkg::BW_DATA], buf_q[fcv_pkg::BW_DATA + 1],
                         buf_q[fcv_pkg::BW_DATA + 2], buf_q[fcv_pkg::BW_DATA + 3]};

  always_comb
  begin
    arr_cmd.we = go && is_pg;
    arr_cmd.info = go && is_ro;
    arr_cmd.wdata = pg_data;
    if (ev_next)
      arr_cmd.addr = cur_addr_q + fcv_pkg::PHRASE_BYTES;
    else if (pg_back)
      arr_cmd.addr = cur_addr_q;
    else
      arr_cmd.addr = is_ro ? ro_addr : op_addr;
  end

  fcv_arr_port u_port (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .start_i(arr_start),
    .cmd_i(arr_cmd),
    .arr_ack_i(arr_ack_i),
    .arr_rsp_i(arr_rsp_i),
    .arr_valid_o(arr_valid_o),
    .arr_req_o(arr_req_o),
    .done_o(arr_done),
    .rsp_o(rsp)
  );

  // Erased means every bit one; program verify compares with the data sent
  wire not_erased = rsp.rdata != fcv_pkg::ERASED;
  wire mismatch = rsp.rdata != pg_data;
  wire rd_chk = arr_done && (st_q == fcv_pkg::ST_EVRD || st_q == fcv_pkg::ST_RORD
                || st_q == fcv_pkg::ST_PGRD);
  // An uncorrectable error counts as an error as well
  wire set_mgs1 = rd_chk && (rsp.err || rsp.uncorr || (st_q == fcv_pkg::ST_EVRD && not_erased)
                  || (st_q == fcv_pkg::ST_PGRD && mismatch));
  wire set_mgs0 = rd_chk && rsp.uncorr;
  wire ro_wb = st_q == fcv_pkg::ST_RORD && arr_done;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      fcv_pkg::ST_IDLE: if (launch) st_d = fcv_pkg::ST_CHECK;
      fcv_pkg::ST_CHECK:
      begin
        if (!go)
          st_d = fcv_pkg::ST_DONE;
        else if (is_ev)
          st_d = fcv_pkg::ST_EVRD;
        else if (is_ro)
          st_d = fcv_pkg::ST_RORD;
        else
          st_d = fcv_pkg::ST_PGWR;
      end
      fcv_pkg::ST_EVRD: if (arr_done && ev_last) st_d = fcv_pkg::ST_DONE;
      fcv_pkg::ST_RORD: if (arr_done) st_d = fcv_pkg::ST_DONE;
      fcv_pkg::ST_PGWR: if (arr_done) st_d = fcv_pkg::ST_PGRD;
      fcv_pkg::ST_PGRD: if (arr_done) st_d = fcv_pkg::ST_DONE;
      fcv_pkg::ST_DONE: st_d = fcv_pkg::ST_IDLE;
      default: st_d = fcv_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      st_q <= fcv_pkg::ST_IDLE;
      cmpl_q <= 1'b1;
      acc_err_q <= 1'b0;
      prot_viol_q <= 1'b0;
      mgs1_q <= 1'b0;
      mgs0_q <= 1'b0;
      cur_addr_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      cmpl_q <= (cmpl_q && !launch) || st_q == fcv_pkg::ST_DONE;
      // Access and protection flags only change while idle or checking, so set and clear never meet
      acc_err_q <= (acc_err_q && !clr_acc) || (chk && cmd_err);
      prot_viol_q <= (prot_viol_q && !clr_fpv)
                     || (chk && !cmd_err && is_pg && pg_prot);
      mgs1_q <= (mgs1_q && !launch) || set_mgs1;
      mgs0_q <= (mgs0_q && !launch) || set_mgs0;
      if (go)
      begin
        cur_addr_q <= is_ro ? ro_addr : op_addr;
        cnt_q <= ev_cnt;
      end
      else if (ev_next)
      begin
        cur_addr_q <= arr_cmd.addr;
        cnt_q <= cnt_q - 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers and command buffer
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      ix_q <= '0;
      permit_q <= fcv_pkg::PERMIT_RST;
      prot_en_q <= 1'b0;
      prot_bound_q <= '0;
      for (int i = 0; i < fcv_pkg::BUF_WORDS; i++)
        buf_q[i] <= '0;
    end
    else
    begin
      if (wr_index)
        ix_q <= avs_writedata_i[2:0];
      if (wr_permit)
        permit_q <= avs_writedata_i[2:0];
      if (wr_prot)
      begin
        prot_en_q <= avs_writedata_i[fcv_pkg::PROT_EN];
        prot_bound_q <= avs_writedata_i[22:0];
      end
      if (wr_buf)
        buf_q[ix_q] <= avs_writedata_i[15:0];
      if (ro_wb)
        for (int w = 0; w < 4; w++)
          buf_q[fcv_pkg::BW_DATA + w] <= rsp.rdata[63 - 16 * w -: 16];
    end
  end

  // ---------------------------------------------------------------
  // Bus answer and fetch path
  // ---------------------------------------------------------------
  wire ro_busy = st_q == fcv_pkg::ST_RORD;
  wire fetch_bad = ro_busy && fcv_pkg::fcv_in_pflash(fetch_addr_i);

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      wait_q <= 1'b1;
      rdata_q <= '0;
      fetch_q <= '0;
      fetch_inv_q <= 1'b0;
    end
    else
    begin
      wait_q <= !req;
      if (req)
        rdata_q <= rd_mux;
      fetch_q <= fetch_bad ? fcv_pkg::FETCH_INVALID : fetch_rdata_i;
      fetch_inv_q <= fetch_bad;
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o = rdata_q;
  assign fetch_rdata_o = fetch_q;
  assign fetch_invalid_o = fetch_inv_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  AST_CMPL_RUN: assert property (st_q != fcv_pkg::ST_IDLE |-> !cmpl_q)
    else $error("complete flag set during operation");
  AST_CMPL_SET: assert property ($rose(cmpl_q) |-> $past(st_q) == fcv_pkg::ST_DONE)
    else $error("complete flag set outside completion");
  AST_EV_IX: assert property (chk && is_ev && ix_q != fcv_pkg::IX_EV
    |=> acc_err_q && st_q == fcv_pkg::ST_DONE)
    else $error("erase-verify index error missed");
  AST_EV_CROSS: assert property (chk && is_ev && ev_cross
    |=> acc_err_q ##1 !arr_valid_o)
    else $error("section crossing not refused");
  AST_EV_ALIGN: assert property (chk && (is_ev || is_pg) && misalign |=> acc_err_q)
    else $error("misaligned address not refused");
  AST_ADDR: assert property (chk && is_ev && addr_bad |=> acc_err_q && !arr_valid_o)
    else $error("invalid address not refused");
  AST_MODE: assert property (chk && is_pg && !permit_q[fcv_pkg::PRM_PG]
    |=> acc_err_q ##1 !arr_valid_o)
    else $error("command outside mode executed");
  AST_RO_IX: assert property (chk && is_ro && ix_q != fcv_pkg::IX_RO |=> acc_err_q)
    else $error("one-time read index error missed");
  AST_RO_RANGE: assert property (chk && is_ro
    && buf_q[fcv_pkg::BW_LO] > fcv_pkg::RO_MAX_IX |=> acc_err_q)
    else $error("phrase index out of range accepted");
  AST_PG_IX: assert property (chk && is_pg && ix_q != fcv_pkg::IX_PG |=> acc_err_q)
    else $error("program index error missed");
  AST_PROT: assert property (chk && is_pg && !pg_err && pg_prot
    |=> prot_viol_q && !acc_err_q ##1 !arr_valid_o)
    else $error("protected program not refused");
  AST_NO_FPV: assert property (chk && (is_ev || is_ro) |=> $stable(prot_viol_q))
    else $error("protection flag changed by read command");
  AST_ERASED: assert property (st_q == fcv_pkg::ST_EVRD && arr_done && not_erased
    |=> mgs1_q)
    else $error("non-erased phrase not flagged");
  AST_UNCORR: assert property (rd_chk && rsp.uncorr |=> mgs0_q && mgs1_q)
    else $error("uncorrectable error not flagged");
  AST_RO_WB: assert property (ro_wb
    |=> buf_q[fcv_pkg::BW_DATA] == $past(rsp.rdata[63:48]))
    else $error("one-time read result not stored");
  AST_PG_BACK: assert property (pg_back
    |=> arr_valid_o && !arr_req_o.we && st_q == fcv_pkg::ST_PGRD)
    else $error("program not followed by read-back");
  AST_FETCH: assert property (fetch_bad
    |=> fetch_invalid_o && fetch_rdata_o == fcv_pkg::FETCH_INVALID)
    else $error("fetch during one-time read not invalidated");

  CV_EV: cover property (st_q == fcv_pkg::ST_EVRD && arr_done && ev_last);
  CV_RO: cover property (ro_wb);
  CV_PG: cover property (st_q == fcv_pkg::ST_PGRD && arr_done);
  CV_ACC: cover property (chk && cmd_err);

endmodule // fcv_sequencer

// ---- test/fcv_sequencer_tb.sv ----
// Self-checking bench for the flash command sequencer
module fcv_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(got, exp, msg) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp); end end

  logic mclk_i;
  logic reset_n_i;
  logic [4:0] avs_address_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0] avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic arr_valid_o;
  fcv_pkg::fcv_arr_req_t arr_req_o;
  logic arr_ack_i;
  fcv_pkg::fcv_arr_rsp_t arr_rsp_i;
  logic [22:0] fetch_addr_i;
  logic [15:0] fetch_rdata_i;
  logic [15:0] fetch_rdata_o;
  logic fetch_invalid_o;
  int n_mismatch;
  int n_tests;
  int n_xfer;
  int ack_dly;
  int wait_cnt;
  logic inj_err;
  logic corrupt;
  logic saw_inv;
  logic bad_fetch;
  logic [23:0] key;
  logic [63:0] mem [logic [23:0]];
  logic [31:0] st;
  logic [31:0] q;
  logic [15:0] w [6];
  logic [22:0] ea [5] = '{23'h7c0000, 23'h7c0004, 23'h000000, 23'h7ffff8, 23'h7ffff8};
  int ecnt [5] = '{1, 1, 1, 2, 1};
  int enw [5] = '{2, 3, 3, 3, 3};
  logic [31:0] eexp [5] = '{32'ha0, 32'ha0, 32'ha0, 32'ha0, 32'h80};
  logic [7:0] ctab [3] = '{fcv_pkg::CMD_EV, fcv_pkg::CMD_RO, fcv_pkg::CMD_PG};
  int ntab [3] = '{3, 2, 6};

  fcv_sequencer dut (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .arr_valid_o(arr_valid_o),
    .arr_req_o(arr_req_o),
    .arr_ack_i(arr_ack_i),
    .arr_rsp_i(arr_rsp_i),
    .fetch_addr_i(fetch_addr_i),
    .fetch_rdata_i(fetch_rdata_i),
    .fetch_rdata_o(fetch_rdata_o),
    .fetch_invalid_o(fetch_invalid_o)
  ); // fcv_sequencer

  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // ---------------------------------------------------------------
  // Array stand-in: erased unless written, response scrambled off ack
  // ---------------------------------------------------------------
  always @(posedge mclk_i)
  begin
    key = {arr_req_o.info, arr_req_o.addr};
    if (arr_valid_o === 1'b1 && !arr_ack_i && wait_cnt >= ack_dly)
    begin
      arr_ack_i <= 1'b1;
      wait_cnt <= 0;
      n_xfer++;
      if (arr_req_o.we)
        mem[key] = arr_req_o.wdata;
      arr_rsp_i.rdata <= (mem.exists(key) ? mem[key] : fcv_pkg::ERASED) ^ {64{corrupt}};
      arr_rsp_i.err <= inj_err;
      arr_rsp_i.uncorr <= inj_err;
    end
    else
    begin
      arr_ack_i <= 1'b0;
      arr_rsp_i <= ~arr_rsp_i;
      if (arr_valid_o === 1'b1 && !arr_ack_i)
        wait_cnt <= wait_cnt + 1;
    end
    if (fetch_invalid_o === 1'b1)
    begin
      saw_inv <= 1'b1;
      if (fetch_rdata_o !== fcv_pkg::FETCH_INVALID)
        bad_fetch <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Bus access and command tasks
  // ---------------------------------------------------------------
  task automatic bus(input logic wr_en, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !wr_en;
    avs_write_i <= wr_en;
    do
    begin
      @(posedge mclk_i);
    end
    while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task automatic setw(input logic [7:0] c, input logic [22:0] a);
    w[0] = {c, 1'b0, a[22:16]};
    w[1] = a[15:0];
  endtask

  // Loads n words, launches, then polls until complete
  task automatic run_cmd(input int n, input logic chk_busy);
    for (int i = 0; i < n; i++)
    begin
      bus(1'b1, fcv_pkg::OFF_INDEX, 32'(i));
      bus(1'b1, fcv_pkg::OFF_BUFWORD, {16'h0000, w[i]});
    end
    n_xfer = 0;
    bus(1'b1, fcv_pkg::OFF_STATUS, 32'h80);
    bus(1'b0, fcv_pkg::OFF_STATUS, 32'h0);
    if (chk_busy)
      `CHK(q[7], 1'b0, "complete flag during run")
    while (q[7] !== 1'b1)
      bus(1'b0, fcv_pkg::OFF_STATUS, 32'h0);
    st = q;
  endtask

  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    #500us;
    n_mismatch++;
    wrap_up();
  end

  initial
  begin
    {avs_read_i, avs_write_i, arr_ack_i, inj_err, corrupt, saw_inv, bad_fetch} = 7'h00;
    {avs_address_i, avs_writedata_i, arr_rsp_i} = '0;
    {n_mismatch, n_tests, n_xfer, ack_dly, wait_cnt} = '0;
    avs_byteenable_i = 4'hf;
    fetch_addr_i = 23'h7c0100;
    fetch_rdata_i = 16'h5a5a;
    reset_n_i = 1'b0;
    repeat (6) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    bus(1'b0, fcv_pkg::OFF_STATUS, 32'h0);
    `CHK(q, 32'h80, "status at reset")
    bus(1'b0, fcv_pkg::OFF_PERMIT, 32'h0);
    `CHK(q, 32'h7, "permit at reset")
    bus(1'b0, 5'h14, 32'h0);
    `CHK(q, 32'h0, "unmapped read")
    // Program with read-back, then a corrupted read-back
    setw(fcv_pkg::CMD_PG, 23'h7c0010);
    {w[2], w[3], w[4], w[5]} = 64'h1234_5678_9abc_def0;
    run_cmd(6, 1'b0);
    `CHK(st, 32'h80, "program status")
    `CHK(mem[{1'b0, 23'h7c0010}], 64'h1234_5678_9abc_def0, "programmed phrase")
    `CHK(n_xfer, 2, "program transfers")
    corrupt = 1'b1;
    setw(fcv_pkg::CMD_PG, 23'h7c0018);
    run_cmd(6, 1'b0);
    corrupt = 1'b0;
    `CHK(st, 32'h82, "read-back mismatch")
    // Erase-verify clean and dirty ranges
    setw(fcv_pkg::CMD_EV, 23'h7c0000);
    w[2] = 16'h0002;
    run_cmd(3, 1'b0);
    `CHK(st, 32'h80, "erased range")
    w[2] = 16'h0003;
    run_cmd(3, 1'b0);
    `CHK(st, 32'h82, "unerased range")
    `CHK(n_xfer, 3, "verify phrase reads")
    for (int i = 0; i < 5; i++)
    begin
      setw(fcv_pkg::CMD_EV, ea[i]);
      w[2] = 16'(ecnt[i]);
      run_cmd(enw[i], 1'b0);
      `CHK(st, eexp[i], "erase-verify check")
      `CHK(n_xfer, eexp[i][5] ? 0 : ecnt[i], "erase-verify reads")
      bus(1'b1, fcv_pkg::OFF_STATUS, 32'h30);
    end
    setw(8'h05, 23'h7c0000);
    run_cmd(3, 1'b0);
    `CHK(st, 32'ha0, "unknown command")
    bus(1'b1, fcv_pkg::OFF_STATUS, 32'h30);
    // One-time read with a slow array
    mem[{1'b1, 23'h000018}] = 64'h1111_2222_3333_4444;
    ack_dly = 8;
    setw(fcv_pkg::CMD_RO, 23'h000003);
    run_cmd(2, 1'b1);
    `CHK(st, 32'h80, "one-time read status")
    for (int i = 2; i < 6; i++)
    begin
      bus(1'b1, fcv_pkg::OFF_INDEX, 32'(i));
      bus(1'b0, fcv_pkg::OFF_BUFWORD, 32'h0);
      `CHK(q[15:0], 16'h1111 * 16'(i - 1), "result word")
    end
    `CHK(saw_inv, 1'b1, "fetch invalidated")
    `CHK(bad_fetch, 1'b0, "invalid fetch data")
    `CHK(fetch_rdata_o, 16'h5a5a, "fetch data after run")
    inj_err = 1'b1;
    run_cmd(2, 1'b0);
    inj_err = 1'b0;
    ack_dly = 0;
    `CHK(st, 32'h83, "read errors")
    w[1] = 16'h0008;
    run_cmd(2, 1'b0);
    `CHK(st, 32'ha0, "phrase index eight")
    bus(1'b1, fcv_pkg::OFF_STATUS, 32'h30);
    w[1] = 16'h0000;
    run_cmd(3, 1'b0);
    `CHK(st, 32'ha0, "one-time read index")
    bus(1'b1, fcv_pkg::OFF_STATUS, 32'h30);
    // No command allowed in the current mode
    bus(1'b1, fcv_pkg::OFF_PERMIT, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      setw(ctab[i], 23'h7c0000);
      w[2] = 16'h0001;
      run_cmd(ntab[i], 1'b0);
      `CHK(st, 32'ha0, "command not permitted")
      `CHK(n_xfer, 0, "no transfer when refused")
      bus(1'b1, fcv_pkg::OFF_STATUS, 32'h30);
    end
    bus(1'b1, fcv_pkg::OFF_PERMIT, 32'h7);
    // Protected region
    bus(1'b1, fcv_pkg::OFF_PROT, 32'h807e_0000);
    setw(fcv_pkg::CMD_PG, 23'h7e0000);
    run_cmd(6, 1'b0);
    `CHK(st, 32'h90, "protected program")
    `CHK(n_xfer, 0, "no protected write")
    bus(1'b1, fcv_pkg::OFF_STATUS, 32'h30);
    setw(fcv_pkg::CMD_EV, 23'h7e0000);
    w[2] = 16'h0001;
    run_cmd(3, 1'b0);
    `CHK(st, 32'h80, "verify in protected region")
    wrap_up();
  end
endmodule // fcv_sequencer_tb
